// File: cbfte_apb_regs.v
// Purpose: control bus slave for the execution core
// Assumes: standard apb master, one word per register
// Notes: answers one cycle into the access phase
`timescale 1ns/10ps
`include "cbfte_consts.vh"
module cbfte_apb_regs (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] i_status_word,
  input wire [7:0] i_view_word,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg [7:0] o_ctrl
);

  reg [31:0] next_rdata; // read mux result
  reg next_err; // unmapped address flag

  // address decode and read mux
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (i_paddr)
      `CBFTE_REG_CTRL: next_rdata = {24'h000000, o_ctrl};
      `CBFTE_REG_STATUS: next_rdata = i_status_word;
      `CBFTE_REG_VIEW: next_rdata = {24'h000000, i_view_word};
      default: next_err = 1'b1;
    endcase
  end

  // access phase handling, one wait state
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_ctrl <= `CBFTE_CTRL_RESET;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      if (i_psel && i_penable && !o_pready) begin
        // answer at the next edge
        o_pready <= 1'b1;
        o_pslverr <= next_err;
        o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
      end
      // write lands at the edge where the master sees ready high
      if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `CBFTE_REG_CTRL) begin
        o_ctrl <= i_pwdata[7:0];
      end
    end
  end

endmodule // cbfte_apb_regs

// File: cbfte_bit_put.v
// Purpose: replace one bit of a word by a given value
// Assumes: index is in range of the word
// Notes: purely combinational
`timescale 1ns/10ps
module cbfte_bit_put #(
  parameter W = 8,
  parameter IW = 3
) (
  input wire [W-1:0] i_value,
  input wire [IW-1:0] i_index,
  input wire i_bit,
  output reg [W-1:0] o_value
);

  // copy the word, then overwrite the chosen bit
  always @* begin
    o_value = i_value;
    o_value[i_index] = i_bit;
  end

endmodule // cbfte_bit_put

// File: cbfte_consts.vh
// Purpose: shared constants for the bit, flag and transfer execution core
// Assumes: included by the core, its bus slave, the checker and the bench; the bit insert module does without
// Notes: opcode and register offsets are local encodings of this core
`ifndef CBFTE_CONSTS_VH
`define CBFTE_CONSTS_VH

// operation codes presented on I_OP
`define CBFTE_OP_NOP 5'h00
`define CBFTE_OP_IO_BIT_SET 5'h01
`define CBFTE_OP_IO_BIT_CLEAR 5'h02
`define CBFTE_OP_BIT_TO_TFLAG 5'h03
`define CBFTE_OP_TFLAG_TO_BIT 5'h04
`define CBFTE_OP_FLAG_SET 5'h05
`define CBFTE_OP_FLAG_CLEAR 5'h06
`define CBFTE_OP_IND_LOAD 5'h07
`define CBFTE_OP_IND_STORE 5'h08
`define CBFTE_OP_DIR_LOAD 5'h09
`define CBFTE_OP_DIR_STORE 5'h0a
`define CBFTE_OP_IO_IN 5'h0b
`define CBFTE_OP_IO_OUT 5'h0c
`define CBFTE_OP_PUSH 5'h0d
`define CBFTE_OP_POP 5'h0e
`define CBFTE_OP_SLEEP 5'h0f
`define CBFTE_OP_WDOG 5'h10
`define CBFTE_OP_BREAK 5'h11

// pointer addressing modes on I_MODE
`define CBFTE_MODE_PLAIN 2'h0
`define CBFTE_MODE_POST_INC 2'h1
`define CBFTE_MODE_PRE_DEC 2'h2

// low register index of each pointer pair
`define CBFTE_PTR_X_LO 4'ha
`define CBFTE_PTR_Y_LO 4'hc
`define CBFTE_PTR_Z_LO 4'he

// status register bit positions
`define CBFTE_STATUS_REGISTER_I 3'h7
`define CBFTE_STATUS_REGISTER_T 3'h6
`define CBFTE_STATUS_REGISTER_RESET 8'h00

// stack pointer reset value
`define CBFTE_SP_RESET 16'h00bf

// register map on the control bus
`define CBFTE_REG_CTRL 8'h00
`define CBFTE_REG_STATUS 8'h04
`define CBFTE_REG_VIEW 8'h08
`define CBFTE_CTRL_RESET 8'h01
`define CBFTE_CTRL_RUN 0

`endif

// File: cbfte_core.v
// Purpose: execution of bit, flag, transfer and control operations
// Assumes: decoded operations arrive on I_OP with operands beside it;
//   data memory answers a read in the cycle its read strobe is high
// Notes: loads write back one edge after issue, with forwarding
//   pointer code 3 reuses the pair of the previous op
//   stack pointer and pointers wrap silently at the ends of their range
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "cbfte_consts.vh"

// Summary of operation
// RULE1: set one io bit, flags untouched, one cycle
// RULE2: clear one io bit, flags untouched, one cycle
// RULE3: copy register bit into transfer flag
// RULE4: copy transfer flag into register bit
// RULE5: set/clear c, n, z, s, v singly
// RULE6: set/clear transfer, half carry, interrupt enable
// RULE7: post-increment load reads, then bumps pointer
// RULE8: pre-decrement load drops pointer, then reads
// RULE9: post-increment store writes, then bumps pointer
// RULE10: pre-decrement store drops pointer, two cycles
// RULE11: direct load from immediate address, one cycle
// RULE12: direct store to immediate address, one cycle
// RULE13: io byte in and out, one cycle
// RULE14: push register on stack, two cycles
// RULE15: pop register from stack, two cycles
// RULE16: sleep issues in one cycle, no flags
// RULE17: watchdog restart in one cycle, no flags
// RULE18: break in one cycle, no flags
// RULE19: one-cycle request pulses for sleep, watchdog, break
module cbfte_core (
  input wire I_CLOCK,
  input wire I_SYS_RST,
  input wire I_INSTR_VALID,
  input wire [4:0] I_OP,
  input wire [1:0] I_MODE,
  input wire [1:0] I_PTR,
  input wire [3:0] I_REG,
  input wire [2:0] I_BIT,
  input wire [15:0] I_ADDR,
  input wire [7:0] I_MEM_RDATA,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg O_READY,
  output reg [15:0] O_MEM_ADDR,
  output reg [7:0] O_MEM_WDATA,
  output reg O_MEM_WE,
  output reg O_MEM_RE,
  output reg O_IO_SEL,
  output reg O_IO_BIT_SET,
  output reg O_IO_BIT_CLR,
  output reg [7:0] O_IO_BIT_MASK,
  output reg O_SLEEP_REQ,
  output reg O_WDR_REQ,
  output reg O_BREAK_REQ,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR
);

  // sequencer states, one-hot
  // only pre-decrement, push and pop visit the second state, for one cycle
  localparam ST_RUN = 2'b01; // taking new operations
  localparam ST_STEP2 = 2'b10; // second cycle of a two-cycle op

  reg [7:0] regs [0:15]; // working registers
  reg [7:0] status_register; // flags i t h s v n z c
  reg [15:0] sp; // stack pointer
  reg [1:0] state; // sequencer state
  reg [4:0] held_op; // op carried into the second cycle
  reg [3:0] held_reg; // register carried into the second cycle
  reg [3:0] held_ptr; // pointer low index carried over
  reg wb_pend; // load result arrives this cycle
  reg [3:0] wb_idx; // destination of that load
  wire [7:0] ctrl; // control register from the bus slave
  wire run_en; // software enable for execution

  reg [3:0] ptr_lo; // low index of the chosen pointer pair
  wire [3:0] src_idx; // source register index for this cycle
  wire [3:0] ptr_hi; // high index of the chosen pointer pair
  wire [7:0] op_src; // source register value, forwarded
  wire [15:0] ptr_val; // pointer value, forwarded
  reg next_ready; // ready for the following cycle
  wire take; // operation accepted at this edge
  wire [7:0] bld_val; // register with transfer flag inserted
  wire [7:0] flag_val; // status register with one flag changed
  wire [31:0] status_word; // state shown on the bus
  wire [7:0] view_word; // register picked for viewing

  // forwarding read of working registers; a load result that lands at this
  // edge is taken from the memory bus so a back-to-back op sees it
  // continuous assigns so every register file write is seen at once
  assign src_idx = state == ST_STEP2 ? held_reg : I_REG;
  assign ptr_hi = ptr_lo + 4'h1;
  assign op_src = (wb_pend && wb_idx == src_idx) ? I_MEM_RDATA : regs[src_idx];
  assign ptr_val = {(wb_pend && wb_idx == ptr_hi) ? I_MEM_RDATA : regs[ptr_hi],
    (wb_pend && wb_idx == ptr_lo) ? I_MEM_RDATA : regs[ptr_lo]};

  assign run_en = ctrl[`CBFTE_CTRL_RUN];
  assign take = I_INSTR_VALID && O_READY && state == ST_RUN;
  assign status_word = {sp, 7'h00, O_READY, status_register};
  assign view_word = regs[ctrl[7:4]];

  // pointer pair selection; the second cycle reuses the pair of the first
  always @* begin
    case (state == ST_STEP2 ? 2'h3 : I_PTR)
      2'h0: ptr_lo = `CBFTE_PTR_X_LO; // pair x
      2'h1: ptr_lo = `CBFTE_PTR_Y_LO; // pair y
      2'h2: ptr_lo = `CBFTE_PTR_Z_LO; // pair z
      default: ptr_lo = held_ptr; // second cycle or invalid code
    endcase
  end

  // readiness for the next cycle, two-cycle ops drop it once
  // clearing the run bit stops new ops; an op in its second cycle still ends
  always @* begin
    next_ready = run_en;
    if (take) begin
      if ((I_OP == `CBFTE_OP_IND_LOAD || I_OP == `CBFTE_OP_IND_STORE) &&
          I_MODE == `CBFTE_MODE_PRE_DEC) begin
        next_ready = 1'b0; // RULE8 RULE10
      end else if (I_OP == `CBFTE_OP_PUSH || I_OP == `CBFTE_OP_POP) begin
        next_ready = 1'b0; // RULE14 RULE15
      end
    end
  end

  // transfer flag into a register bit
  cbfte_bit_put #(.W(8), .IW(3)) u_bld (
    .i_value(op_src),
    .i_index(I_BIT),
    .i_bit(status_register[`CBFTE_STATUS_REGISTER_T]),
    .o_value(bld_val)
  );

  // one status flag forced to the op's value
  cbfte_bit_put #(.W(8), .IW(3)) u_flag (
    .i_value(status_register),
    .i_index(I_BIT),
    .i_bit(I_OP == `CBFTE_OP_FLAG_SET),
    .o_value(flag_val)
  );

  // control bus slave
  // run enable and view index come back as ctrl
  cbfte_apb_regs u_regs (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_psel(I_PSEL),
    .i_penable(I_PENABLE),
    .i_pwrite(I_PWRITE),
    .i_paddr(I_PADDR),
    .i_pwdata(I_PWDATA),
    .i_status_word(status_word),
    .i_view_word(view_word),
    .o_prdata(O_PRDATA),
    .o_pready(O_PREADY),
    .o_pslverr(O_PSLVERR),
    .o_ctrl(ctrl)
  );

  // register file writes: older load result first, newer op wins
  // a load result and a new op may write one register at the same edge;
  // the new op's value is the one that stays
  // working registers have no reset value, software loads them first
  always @(posedge I_CLOCK) begin
    if (wb_pend) begin
      regs[wb_idx] <= I_MEM_RDATA;
    end
    if (take) begin
      case (I_OP)
        `CBFTE_OP_TFLAG_TO_BIT: regs[I_REG] <= bld_val; // RULE4
        `CBFTE_OP_IND_LOAD, `CBFTE_OP_IND_STORE: begin
          if (I_MODE == `CBFTE_MODE_POST_INC) begin
            // bump after the access address is taken
            regs[ptr_lo] <= ptr_val[7:0] + 8'h01; // RULE7 RULE9
            regs[ptr_lo + 4'h1] <= ptr_val[15:8] + {7'h00, &ptr_val[7:0]};
          end else if (I_MODE == `CBFTE_MODE_PRE_DEC) begin
            // drop first, access in the next cycle
            regs[ptr_lo] <= ptr_val[7:0] - 8'h01; // RULE8 RULE10
            regs[ptr_lo + 4'h1] <= ptr_val[15:8] - {7'h00, ~|ptr_val[7:0]};
          end
        end
        default: begin
          // no register write
        end
      endcase
    end
  end

  // sequencer, flags, stack pointer and outward strobes
  always @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      // ready stays low in reset and rises at the first edge after it
      state <= ST_RUN;
      status_register <= `CBFTE_STATUS_REGISTER_RESET;
      sp <= `CBFTE_SP_RESET;
      held_op <= `CBFTE_OP_NOP;
      held_reg <= 4'h0;
      held_ptr <= 4'h0;
      wb_pend <= 1'b0;
      wb_idx <= 4'h0;
      O_READY <= 1'b0;
      O_MEM_ADDR <= 16'h0000;
      O_MEM_WDATA <= 8'h00;
      O_MEM_WE <= 1'b0;
      O_MEM_RE <= 1'b0;
      O_IO_SEL <= 1'b0;
      O_IO_BIT_SET <= 1'b0;
      O_IO_BIT_CLR <= 1'b0;
      O_IO_BIT_MASK <= 8'h00;
      O_SLEEP_REQ <= 1'b0;
      O_WDR_REQ <= 1'b0;
      O_BREAK_REQ <= 1'b0;
    end else begin
      // strobes last one cycle unless raised again
      O_READY <= next_ready;
      O_MEM_WE <= 1'b0;
      O_MEM_RE <= 1'b0;
      O_IO_SEL <= 1'b0;
      O_IO_BIT_SET <= 1'b0;
      O_IO_BIT_CLR <= 1'b0;
      O_SLEEP_REQ <= 1'b0;
      O_WDR_REQ <= 1'b0;
      O_BREAK_REQ <= 1'b0;
      wb_pend <= 1'b0;
      case (state)
        ST_RUN: begin
          if (take) begin
            // operands kept for a possible second cycle
            held_op <= I_OP;
            held_reg <= I_REG;
            held_ptr <= ptr_lo;
            case (I_OP)
              `CBFTE_OP_IO_BIT_SET, `CBFTE_OP_IO_BIT_CLEAR: begin
                // io unit applies the mask; no flags touched
                // the mask is held after the pulse, only the strobes fall
                O_MEM_ADDR <= I_ADDR;
                O_IO_SEL <= 1'b1;
                O_IO_BIT_MASK <= 8'h01 << I_BIT;
                O_IO_BIT_SET <= I_OP == `CBFTE_OP_IO_BIT_SET; // RULE1
                O_IO_BIT_CLR <= I_OP == `CBFTE_OP_IO_BIT_CLEAR; // RULE2
              end
              `CBFTE_OP_BIT_TO_TFLAG: begin
                status_register[`CBFTE_STATUS_REGISTER_T] <= op_src[I_BIT]; // RULE3
              end
              `CBFTE_OP_FLAG_SET, `CBFTE_OP_FLAG_CLEAR: begin
                // bit number: 7 i, 6 t, 5 h, 4 s, 3 v, 2 n, 1 z, 0 c
                // one flag, selected by bit number, others kept
                status_register <= flag_val; // RULE5 RULE6
              end
              `CBFTE_OP_IND_LOAD: begin
                if (I_MODE != `CBFTE_MODE_PRE_DEC) begin
                  O_MEM_ADDR <= ptr_val; // RULE7
                  O_MEM_RE <= 1'b1;
                  wb_pend <= 1'b1;
                  wb_idx <= I_REG;
                end else begin
                  state <= ST_STEP2; // RULE8
                end
              end
              `CBFTE_OP_IND_STORE: begin
                if (I_MODE != `CBFTE_MODE_PRE_DEC) begin
                  O_MEM_ADDR <= ptr_val; // RULE9
                  O_MEM_WDATA <= op_src;
                  O_MEM_WE <= 1'b1;
                end else begin
                  state <= ST_STEP2; // RULE10
                end
              end
              `CBFTE_OP_DIR_LOAD, `CBFTE_OP_IO_IN: begin
                // immediate address, result written back next edge
                O_MEM_ADDR <= I_ADDR; // RULE11 RULE13
                O_MEM_RE <= 1'b1;
                O_IO_SEL <= I_OP == `CBFTE_OP_IO_IN;
                wb_pend <= 1'b1;
                wb_idx <= I_REG;
              end
              `CBFTE_OP_DIR_STORE, `CBFTE_OP_IO_OUT: begin
                O_MEM_ADDR <= I_ADDR; // RULE12 RULE13
                O_MEM_WDATA <= op_src;
                O_MEM_WE <= 1'b1;
                O_IO_SEL <= I_OP == `CBFTE_OP_IO_OUT;
              end
              `CBFTE_OP_PUSH: begin
                // the stack grows downward; sp points at the next free byte
                // write at the top, then move the pointer down
                O_MEM_ADDR <= sp; // RULE14
                O_MEM_WDATA <= op_src;
                O_MEM_WE <= 1'b1;
                sp <= sp - 16'h0001;
                state <= ST_STEP2;
              end
              `CBFTE_OP_POP: begin
                // move the pointer up, read in the second cycle
                // the read address is the pointer after the increment
                sp <= sp + 16'h0001; // RULE15
                state <= ST_STEP2;
              end
              // requests to power, watchdog and debug logic, one cycle each
              `CBFTE_OP_SLEEP: O_SLEEP_REQ <= 1'b1; // RULE16 RULE19
              `CBFTE_OP_WDOG: O_WDR_REQ <= 1'b1; // RULE17 RULE19
              `CBFTE_OP_BREAK: O_BREAK_REQ <= 1'b1; // RULE18 RULE19
              default: begin
                // no operation
              end
            endcase
          end
        end
        ST_STEP2: begin
          // one extra cycle only, then back to taking ops
          state <= ST_RUN;
          case (held_op)
            `CBFTE_OP_IND_LOAD: begin
              // pointer already dropped, read the new address
              O_MEM_ADDR <= ptr_val; // RULE8
              O_MEM_RE <= 1'b1;
              wb_pend <= 1'b1;
              wb_idx <= held_reg;
            end
            `CBFTE_OP_IND_STORE: begin
              O_MEM_ADDR <= ptr_val; // RULE10
              O_MEM_WDATA <= op_src;
              O_MEM_WE <= 1'b1;
            end
            `CBFTE_OP_POP: begin
              O_MEM_ADDR <= sp; // RULE15
              O_MEM_RE <= 1'b1;
              wb_pend <= 1'b1;
              wb_idx <= held_reg;
            end
            default: begin
              // push needs no second access
            end
          endcase
        end
        default: state <= ST_RUN;
      endcase
    end
  end

endmodule // cbfte_core

// File: cbfte_core_assertions.sv
// Purpose: timing checks on the operation port of the execution core
// Assumes: bound to cbfte_core, one clock domain
// Notes: an operation is taken when valid and ready meet
`timescale 1ns/10ps
`include "cbfte_consts.vh"
module cbfte_chk (
  input wire I_CLOCK,
  input wire I_SYS_RST,
  input wire I_INSTR_VALID,
  input wire [4:0] I_OP,
  input wire [1:0] I_MODE,
  input wire [2:0] I_BIT,
  input wire O_READY,
  input wire O_MEM_WE,
  input wire O_MEM_RE,
  input wire O_IO_SEL,
  input wire O_IO_BIT_SET,
  input wire O_IO_BIT_CLR,
  input wire [7:0] O_IO_BIT_MASK,
  input wire O_SLEEP_REQ,
  input wire O_WDR_REQ,
  input wire O_BREAK_REQ
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  wire take = I_INSTR_VALID && O_READY; // operation accepted
  wire pre = I_MODE == `CBFTE_MODE_PRE_DEC; // pre-decrement mode
  // stall cycle, then read strobe with ready back
  sequence s_stall_rd;
    !O_READY && !O_MEM_RE ##1 O_MEM_RE && O_READY;
  endsequence
  // stall cycle, then write strobe with ready back
  sequence s_stall_wr;
    !O_READY && !O_MEM_WE ##1 O_MEM_WE && O_READY;
  endsequence
  property p_bit_set;
    take && I_OP == `CBFTE_OP_IO_BIT_SET |=> O_IO_SEL && O_IO_BIT_SET && !O_IO_BIT_CLR
      && O_IO_BIT_MASK == (8'h01 << $past(I_BIT));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("io bit set pulse wrong");
  property p_bit_clr;
    take && I_OP == `CBFTE_OP_IO_BIT_CLEAR |=> O_IO_SEL && O_IO_BIT_CLR && !O_IO_BIT_SET
      && O_IO_BIT_MASK == (8'h01 << $past(I_BIT));
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("io bit clear pulse wrong");
  property p_pre_ld;
    take && I_OP == `CBFTE_OP_IND_LOAD && pre |=> s_stall_rd;
  endproperty
  a_pre_ld: assert property (p_pre_ld) else $error("pre-dec load timing wrong");
  property p_post_st;
    take && I_OP == `CBFTE_OP_IND_STORE && I_MODE == `CBFTE_MODE_POST_INC
      |=> O_MEM_WE && !O_IO_SEL && O_READY;
  endproperty
  a_post_st: assert property (p_post_st) else $error("post-inc store wrong");
  property p_pre_st;
    take && I_OP == `CBFTE_OP_IND_STORE && pre |=> s_stall_wr;
  endproperty
  a_pre_st: assert property (p_pre_st) else $error("pre-dec store timing wrong");
  property p_dir_ld;
    take && I_OP == `CBFTE_OP_DIR_LOAD |=> O_MEM_RE && !O_IO_SEL && O_READY;
  endproperty
  a_dir_ld: assert property (p_dir_ld) else $error("direct load strobe wrong");
  property p_push;
    take && I_OP == `CBFTE_OP_PUSH |=> O_MEM_WE && !O_READY ##1 O_READY && !O_MEM_WE;
  endproperty
  a_push: assert property (p_push) else $error("push timing wrong");
  property p_pop;
    take && I_OP == `CBFTE_OP_POP |=> s_stall_rd;
  endproperty
  a_pop: assert property (p_pop) else $error("pop timing wrong");
  property p_sleep;
    take && I_OP == `CBFTE_OP_SLEEP |=> O_SLEEP_REQ && !O_WDR_REQ && !O_BREAK_REQ;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request missing");
  property p_wdr;
    O_WDR_REQ == $past(take && I_OP == `CBFTE_OP_WDOG);
  endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog request wrong");
  property p_brk;
    take && I_OP == `CBFTE_OP_BREAK |=> O_BREAK_REQ && !O_SLEEP_REQ;
  endproperty
  a_brk: assert property (p_brk) else $error("break request missing");
endmodule // cbfte_chk

bind cbfte_core cbfte_chk u_chk (.I_CLOCK, .I_SYS_RST, .I_INSTR_VALID, .I_OP, .I_MODE,
  .I_BIT, .O_READY, .O_MEM_WE, .O_MEM_RE, .O_IO_SEL, .O_IO_BIT_SET, .O_IO_BIT_CLR,
  .O_IO_BIT_MASK, .O_SLEEP_REQ, .O_WDR_REQ, .O_BREAK_REQ);

// File: cbfte_mem_model.sv
// Purpose: data memory and io space on the far side of the execution core
// Assumes: read data is wanted in the cycle the read strobe is high
// Notes: an idle read bus shows the inverse of the last byte read
`timescale 1ns/10ps
module cbfte_mem_model (
  input wire i_clk,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_we,
  input wire i_re,
  input wire i_io,
  input wire i_bset,
  input wire i_bclr,
  input wire [7:0] i_mask,
  output wire [7:0] o_rdata
);
  reg [7:0] mem [0:255]; // data space
  reg [7:0] io [0:63]; // io locations
  reg [7:0] last = 8'h00; // last byte read
  wire [7:0] cur = i_io ? io[i_addr[5:0]] : mem[i_addr[7:0]]; // addressed byte
  integer k;
  // seed data with a pattern the bench recomputes
  initial begin
    for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5a;
    for (k = 0; k < 64; k = k + 1) io[k] = 8'h00;
  end
  // no stale byte left on an idle bus
  assign o_rdata = i_re ? cur : ~last;
  // writes and io bit updates; bit pulses win over a write
  always @(posedge i_clk) begin
    if (i_re) last <= cur;
    if (i_we && i_io) io[i_addr[5:0]] <= i_wdata;
    if (i_we && !i_io) mem[i_addr[7:0]] <= i_wdata;
    if (i_bset) io[i_addr[5:0]] <= io[i_addr[5:0]] | i_mask;
    if (i_bclr) io[i_addr[5:0]] <= io[i_addr[5:0]] & ~i_mask;
  end
endmodule // cbfte_mem_model

// File: tb_top.sv
// Purpose: self-checking bench for the execution core
// Assumes: registers seen through the apb view and status words
// Notes: memory model seeds each data byte with its address xor 5a
`timescale 1ns/10ps
`include "cbfte_consts.vh"
module tb_top;
  reg I_CLOCK = 1'b0; // system clock
  reg I_SYS_RST = 1'b1; // reset, active high
  reg I_INSTR_VALID = 1'b0; // operation offered
  reg [4:0] I_OP = 5'h00;
  reg [1:0] I_MODE = 2'h0;
  reg [1:0] I_PTR = 2'h0;
  reg [3:0] I_REG = 4'h0;
  reg [2:0] I_BIT = 3'h0;
  reg [15:0] I_ADDR = 16'h0000;
  reg I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
  reg [7:0] I_PADDR = 8'h00;
  reg [31:0] I_PWDATA = 32'h00000000;
  wire [7:0] I_MEM_RDATA, O_MEM_WDATA, O_IO_BIT_MASK;
  wire [15:0] O_MEM_ADDR;
  wire O_READY, O_MEM_WE, O_MEM_RE, O_IO_SEL, O_IO_BIT_SET, O_IO_BIT_CLR;
  wire [31:0] O_PRDATA;
  wire O_PREADY, O_PSLVERR;
  wire O_SLEEP_REQ, O_WDR_REQ, O_BREAK_REQ; // control requests
  reg [2:0] reqs = 3'h0; // requests seen so far
  integer fails = 0, n_tests = 0, i;
  reg [7:0] rg [0:15]; // expected working registers
  reg [7:0] sr = 8'h00; // expected status register
  reg [7:0] p; // pointer value under test
  reg [3:0] lo; // low register of that pointer
  reg [31:0] d; // last apb read data
  reg e; // last apb error flag
  always #5 I_CLOCK = ~I_CLOCK;
  cbfte_core u_cbfte_core (.I_CLOCK, .I_SYS_RST, .I_INSTR_VALID, .I_OP, .I_MODE, .I_PTR,
    .I_REG, .I_BIT, .I_ADDR, .I_MEM_RDATA, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .O_READY, .O_MEM_ADDR, .O_MEM_WDATA, .O_MEM_WE, .O_MEM_RE, .O_IO_SEL,
    .O_IO_BIT_SET, .O_IO_BIT_CLR, .O_IO_BIT_MASK, .O_SLEEP_REQ, .O_WDR_REQ,
    .O_BREAK_REQ, .O_PRDATA, .O_PREADY, .O_PSLVERR);
  // gather control request pulses for the closing check
  always @(posedge I_CLOCK) begin
    if (!I_SYS_RST) reqs <= reqs | {O_BREAK_REQ, O_WDR_REQ, O_SLEEP_REQ};
  end
  cbfte_mem_model u_mem (.i_clk(I_CLOCK), .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA),
    .i_we(O_MEM_WE), .i_re(O_MEM_RE), .i_io(O_IO_SEL), .i_bset(O_IO_BIT_SET),
    .i_bclr(O_IO_BIT_CLR), .i_mask(O_IO_BIT_MASK), .o_rdata(I_MEM_RDATA));
  // compare and count
  task chk(input [8*5:1] nm, input [31:0] ex, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== ex) begin
        $display("unexpected %0s exp %h got %h", nm, ex, got);
        fails = fails + 1;
      end
    end
  endtask
  // one apb transfer; ends an edge after release
  task apb(input w, input [7:0] a, input [31:0] wd);
    begin
      I_INSTR_VALID <= 1'b0;
      I_PSEL <= 1'b1;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= wd;
      @(posedge I_CLOCK);
      I_PENABLE <= 1'b1;
      @(posedge I_CLOCK);
      while (O_PREADY !== 1'b1) @(posedge I_CLOCK);
      d = O_PRDATA;
      e = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
      @(posedge I_CLOCK);
    end
  endtask
  // offer an operation and hold it until taken
  task op(input [4:0] o, input [1:0] m, input [3:0] r, input [2:0] b, input [15:0] a);
    begin
      I_OP <= o;
      I_MODE <= m;
      I_REG <= r;
      I_BIT <= b;
      I_ADDR <= a;
      I_INSTR_VALID <= 1'b1;
      @(posedge I_CLOCK);
      while (O_READY !== 1'b1) @(posedge I_CLOCK);
    end
  endtask
  // read a working register through the view word
  task ckr(input [3:0] r);
    begin
      apb(1'b1, 8'h00, {24'h0, r, 4'h1});
      apb(1'b0, 8'h08, 32'h0);
      chk("reg", rg[r], d[7:0]);
      chk("err", 1'b0, e);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // cut a hang short; the tests need about two hundred and fifty cycles
  initial begin
    #200000;
    fails = fails + 1;
    final_report;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge I_CLOCK);
    I_SYS_RST <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    apb(1'b0, 8'h0c, 32'h0);
    chk("err", 1'b1, e);
    // flags set one by one, then all but the interrupt enable cleared
    for (i = 0; i < 15; i = i + 1) begin
      op(i < 8 ? `CBFTE_OP_FLAG_SET : `CBFTE_OP_FLAG_CLEAR, 2'h0, 4'h0, i[2:0], 16'h0);
      sr[i[2:0]] = (i < 8);
      apb(1'b0, 8'h04, 32'h0);
      chk("flags", sr, d[7:0]);
    end
    op(`CBFTE_OP_DIR_LOAD, 2'h0, 4'h3, 3'h0, 16'h0040);
    rg[3] = 8'h1a;
    p = 8'h60;
    lo = 4'ha;
    // each pointer: loads and stores back to back, pointer returns to start
    for (i = 0; i < 3; i = i + 1) begin
      I_PTR <= i[1:0];
      op(`CBFTE_OP_DIR_LOAD, 2'h0, lo, 3'h0, {8'h00, p ^ 8'h5a});
      op(`CBFTE_OP_DIR_LOAD, 2'h0, lo + 4'h1, 3'h0, 16'h005a);
      op(`CBFTE_OP_IND_LOAD, `CBFTE_MODE_POST_INC, 4'h1, 3'h0, 16'h0);
      op(`CBFTE_OP_IND_STORE, `CBFTE_MODE_POST_INC, 4'h3, 3'h0, 16'h0);
      op(`CBFTE_OP_IND_LOAD, `CBFTE_MODE_PRE_DEC, 4'h2, 3'h0, 16'h0);
      op(`CBFTE_OP_IND_STORE, `CBFTE_MODE_PRE_DEC, 4'h3, 3'h0, 16'h0);
      rg[1] = p ^ 8'h5a;
      rg[2] = 8'h1a;
      rg[lo] = p;
      ckr(4'h1);
      ckr(4'h2);
      ckr(lo);
      chk("mem", 8'h1a, u_mem.mem[p]);
      chk("mem", 8'h1a, u_mem.mem[p + 8'h01]);
      p = p + 8'h08;
      lo = lo + 4'h2;
    end
    op(`CBFTE_OP_PUSH, 2'h0, 4'h1, 3'h0, 16'h0);
    op(`CBFTE_OP_PUSH, 2'h0, 4'h2, 3'h0, 16'h0);
    op(`CBFTE_OP_POP, 2'h0, 4'h4, 3'h0, 16'h0);
    op(`CBFTE_OP_POP, 2'h0, 4'h5, 3'h0, 16'h0);
    rg[4] = rg[2];
    rg[5] = rg[1];
    chk("stack", rg[1], u_mem.mem[8'hbf]);
    ckr(4'h4);
    ckr(4'h5);
    apb(1'b0, 8'h04, 32'h0);
    chk("sp", 16'h00bf, d[31:16]);
    chk("flags", sr, d[7:0]);
    op(`CBFTE_OP_IO_OUT, 2'h0, 4'h1, 3'h0, 16'h0005);
    op(`CBFTE_OP_IO_BIT_SET, 2'h0, 4'h0, 3'h7, 16'h0005);
    op(`CBFTE_OP_IO_BIT_CLEAR, 2'h0, 4'h0, 3'h1, 16'h0005);
    op(`CBFTE_OP_IO_IN, 2'h0, 4'h6, 3'h0, 16'h0005);
    op(`CBFTE_OP_DIR_STORE, 2'h0, 4'h6, 3'h0, 16'h0090);
    rg[6] = (rg[1] | 8'h80) & 8'hfd;
    ckr(4'h6);
    chk("mem", rg[6], u_mem.mem[8'h90]);
    op(`CBFTE_OP_BIT_TO_TFLAG, 2'h0, 4'h6, 3'h7, 16'h0);
    op(`CBFTE_OP_TFLAG_TO_BIT, 2'h0, 4'h5, 3'h0, 16'h0);
    op(`CBFTE_OP_BIT_TO_TFLAG, 2'h0, 4'h6, 3'h0, 16'h0);
    op(`CBFTE_OP_TFLAG_TO_BIT, 2'h0, 4'h4, 3'h1, 16'h0);
    chk("reqs", 3'h0, reqs);
    op(`CBFTE_OP_SLEEP, 2'h0, 4'h0, 3'h0, 16'h0);
    op(`CBFTE_OP_WDOG, 2'h0, 4'h0, 3'h0, 16'h0);
    op(`CBFTE_OP_BREAK, 2'h0, 4'h0, 3'h0, 16'h0);
    rg[5] = rg[5] | 8'h01;
    rg[4] = rg[4] & 8'hfd;
    ckr(4'h5);
    ckr(4'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk("flags", sr, d[7:0]);
    chk("reqs", 3'h7, reqs);
    final_report;
  end
endmodule // tb_top
